// *** dv/core_model.sv ***
// Core-side model that executes instructions whose fetch came back blocked.
`timescale 1ns/1ps
module core_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic execOn,
  input  wire logic iRspXn,
  output logic      iExecMarked
);
  // ****************************************************************
  // Execution marker
  // ****************************************************************
  // A blocked fetch is executed a cycle after it returns, so the fault must come late.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      iExecMarked <= 1'b0;
    end else begin
      iExecMarked <= iRspXn && execOn;
    end
  end
endmodule

// *** dv/tb_top.sv ***
// Self-checking testbench of the region protection unit.
`timescale 1ns/1ps
module tb_top;
  import region_protection_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                                  clk = 1'b0;
  logic                                  reset_n = 1'b0;
  logic [NUM_REGIONS-1:0]                regionEnable, regionShare, regionXn;
  logic [NUM_REGIONS-1:0]                regionPrivOnly, regionReadOnly;
  logic [NUM_REGIONS-1:0][31:0]          regionBase, regionLimit;
  mem_type_e [NUM_REGIONS-1:0]           regionType;
  logic [NUM_REGIONS-1:0][NUM_PORTS-1:0] regionPrimaryMask;
  logic                                  backgroundEnable, iValid, iPriv, iExecMarked, execOn;
  logic                                  dValid, dWrite, dPriv, dmaValid, dmaWrite;
  logic [31:0]                           iAddr, dAddr, dWdata, dmaAddr, dmaWdata;
  logic                                  iRspValid, iRspXn, iFault, xnFault, trapPulse;
  logic                                  dReady, dRspValid, dFault, dmaReady, dmaRspValid, dmaFault;
  logic [31:0]                           iRspData, dRspData, dmaRspData;
  logic [1:0]                            trapSource;
  int                                    badCount = 0;
  int                                    checkCount = 0;

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  region_protection_unit u_dut (.clk, .reset_n, .regionEnable, .regionBase, .regionLimit,
    .regionType, .regionShare, .regionXn, .regionPrivOnly, .regionReadOnly,
    .regionPrimaryMask, .backgroundEnable, .iValid, .iAddr, .iPriv, .iExecMarked, .iRspValid,
    .iRspData, .iRspXn, .iFault, .xnFault, .dValid, .dReady, .dWrite, .dAddr, .dWdata, .dPriv,
    .dRspValid, .dRspData, .dFault, .dmaValid, .dmaReady, .dmaWrite, .dmaAddr, .dmaWdata,
    .dmaRspValid, .dmaRspData, .dmaFault, .trapPulse, .trapSource);

  core_model u_core (.clk, .reset_n, .execOn, .iRspXn, .iExecMarked);

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // Moves to just after the n-th next rising edge, where inputs change.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Flags are {share, exec forbidden, privileged only, read only}.
  task automatic setRegion(input int n, input logic [31:0] b, input logic [31:0] l,
                           input mem_type_e t, input logic [2:0] m, input logic [3:0] f);
    regionEnable[n] = 1'b1;
    regionBase[n] = b;
    regionLimit[n] = l;
    regionType[n] = t;
    regionPrimaryMask[n] = m;
    {regionShare[n], regionXn[n], regionPrivOnly[n], regionReadOnly[n]} = f;
  endtask

  // Holds the request until an edge at which ready was high has taken it.
  task automatic dIssue(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    dValid = 1'b1;
    dWrite = wr;
    dAddr = a;
    dWdata = wd;
    while (dReady !== 1'b1) tick(1);
    tick(1);
  endtask

  task automatic dResp(input int expLat, input logic expFault, input logic [31:0] expData,
                       input logic chk);
    int lat;
    lat = 1;
    while (dRspValid !== 1'b1 && lat < 4) begin
      tick(1);
      lat++;
    end
    check(lat, expLat, "D latency");
    check(dFault, expFault, "D fault");
    check(trapPulse, expFault, "trap pulse");
    if (expFault) check(trapSource, 2'h1, "trap source D");
    if (chk) check(dRspData, expData, "D data");
  endtask

  task automatic dOne(input logic wr, input logic [31:0] a, input logic pv, input logic f);
    dPriv = pv;
    dIssue(wr, a, a);
    dValid = 1'b0;
    dResp(1, f, a, 1'b0);
    tick(1);
  endtask

  task automatic dmaOne(input logic [31:0] a, input int expLat, input logic f);
    int lat;
    dmaValid = 1'b1;
    dmaWrite = 1'b0;
    dmaAddr = a;
    while (dmaReady !== 1'b1) tick(1);
    tick(1);
    dmaValid = 1'b0;
    lat = 1;
    while (dmaRspValid !== 1'b1 && lat < 4) begin
      tick(1);
      lat++;
    end
    check(lat, expLat, "DMA latency");
    check(dmaFault, f, "DMA fault");
    if (f) check(trapSource, 2'h2, "trap source DMA");
  endtask

  task automatic iFetch(input logic [31:0] a, input logic expXn, input logic f);
    iValid = 1'b1;
    iAddr = a;
    tick(1);
    iValid = 1'b0;
    check(iRspValid, 1'b1, "I valid");
    check(iRspXn, expXn, "I blocked");
    check(iFault, f, "I fault");
    check(xnFault, 1'b0, "no fault on fetch");
    if (f) check(trapSource, 2'h0, "trap source I");
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // A write, buffered unless strong, followed at once by a read decides the read latency.
  task automatic dPair(input logic [31:0] wa, input logic [31:0] ra, input int lat,
                       input logic chk);
    dPriv = 1'b1;
    dIssue(1'b1, wa, wa ^ 32'h5A5A_0000);
    dIssue(1'b0, ra, 32'h0000_0000);
    dValid = 1'b0;
    dResp(lat, 1'b0, wa ^ 32'h5A5A_0000, chk);
    tick(2);
  endtask

  task automatic dmaAfterWrite(input logic [31:0] wa, input logic [31:0] ra, input int lat);
    dPriv = 1'b1;
    dIssue(1'b1, wa, wa);
    dValid = 1'b0;
    dmaOne(ra, lat, 1'b0);
    tick(2);
  endtask

  // Reads right behind a processor write, buffered or strong, on every memory type.
  task automatic testOrder();
    dPair(32'h100, 32'h104, 1, 1'b0);
    dPair(32'h110, 32'h110, 2, 1'b1);
    dPair(32'h1000, 32'h1004, 2, 1'b0);
    dPair(32'h120, 32'h2000, 2, 1'b0);
    dPair(32'h2010, 32'h2010, 1, 1'b1);
    $display("ordering test done");
  endtask

  // DMA behind a processor write; on the non-shareable region the stimulus
  // keeps coherency itself by touching another word.
  task automatic testShare();
    dmaAfterWrite(32'h180, 32'h184, 2);
    dmaAfterWrite(32'h5000, 32'h5004, 1);
    dmaAfterWrite(32'h190, 32'h2004, 2);
    $display("sharing test done");
  endtask

  // Permission table: background, privilege, overlap, read-only and primary masks.
  task automatic testFaults();
    dOne(1'b0, 32'h9000, 1'b1, 1'b1);
    backgroundEnable = 1'b1;
    dOne(1'b0, 32'h9000, 1'b1, 1'b0);
    dOne(1'b0, 32'h9000, 1'b0, 1'b1);
    backgroundEnable = 1'b0;
    dOne(1'b0, 32'h5000, 1'b0, 1'b1);
    dOne(1'b0, 32'h5000, 1'b1, 1'b0);
    dOne(1'b1, 32'h0800, 1'b1, 1'b1);
    dOne(1'b1, 32'h0900, 1'b1, 1'b0);
    dmaOne(32'h4000, 1, 1'b1);
    dmaOne(32'h0200, 1, 1'b0);
    iFetch(32'h4000, 1'b0, 1'b1);
    $display("fault table done");
  endtask

  // Three primaries read separate words in the same cycle.
  task automatic testParallel();
    for (int k = 0; k < 3; k++) dOne(1'b1, 32'h300 + 4 * k, 1'b1, 1'b0);
    iValid = 1'b1;
    iAddr = 32'h300;
    dValid = 1'b1;
    dWrite = 1'b0;
    dAddr = 32'h304;
    dmaValid = 1'b1;
    dmaAddr = 32'h308;
    tick(1);
    iValid = 1'b0;
    dValid = 1'b0;
    dmaValid = 1'b0;
    check(iRspValid & dRspValid & dmaRspValid, 1'b1, "parallel valid");
    check(iRspData, 32'h300, "I data");
    check(dRspData, 32'h304, "D data");
    check(dmaRspData, 32'h308, "DMA data");
    tick(1);
    $display("parallel done");
  endtask

  // Blocked fetch faults only once the core executes it.
  task automatic testExec(input logic on);
    execOn = on;
    iFetch(32'h3000, 1'b1, 1'b0);
    tick(2);
    check(xnFault, on, "execute fault");
    execOn = 1'b0;
    tick(1);
    $display("execute test done");
  endtask

  // Time-zero values, reset, then the scenarios in order.
  initial begin
    {regionEnable, regionShare, regionXn, regionPrivOnly, regionReadOnly} = '0;
    {regionBase, regionLimit, regionPrimaryMask} = '0;
    regionType = '{default: MEM_NORMAL};
    {backgroundEnable, iValid, iPriv, execOn, dValid, dWrite, dPriv, dmaValid, dmaWrite} = '0;
    {iAddr, dAddr, dWdata, dmaAddr, dmaWdata} = '0;
    setRegion(0, 32'h0000, 32'h0FFF, MEM_NORMAL, 3'h7, 4'h8);
    setRegion(1, 32'h1000, 32'h1FFF, MEM_DEVICE, 3'h7, 4'h0);
    setRegion(2, 32'h2000, 32'h2FFF, MEM_STRONG, 3'h7, 4'h0);
    setRegion(3, 32'h3000, 32'h3FFF, MEM_NORMAL, 3'h3, 4'h4);
    setRegion(4, 32'h4000, 32'h4FFF, MEM_NORMAL, 3'h2, 4'h0);
    setRegion(5, 32'h5000, 32'h5FFF, MEM_NORMAL, 3'h7, 4'h2);
    setRegion(6, 32'h0800, 32'h08FF, MEM_NORMAL, 3'h7, 4'h9);
    iPriv = 1'b1;
    tick(6);
    check({dReady, dmaReady, trapPulse, dRspValid}, 4'hC, "reset outputs");
    reset_n = 1'b1;
    tick(1);
    testOrder();
    testShare();
    testFaults();
    testExec(1'b1);
    testExec(1'b0);
    testParallel();
    printVerdict();
  end

  // Watchdog far beyond the fewer than one hundred cycles the scenarios need.
  initial begin
    #50000;
    badCount++;
    printVerdict();
  end

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
endmodule

// *** verilog/multiport_ram.sv ***
// Three-port RAM with one read and one write path per primary.
`timescale 1ns/1ps
module multiport_ram
  import region_protection_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                reset_n,
  input  wire logic [NUM_PORTS-1:0]                rdEn,
  input  wire logic [NUM_PORTS-1:0][RAM_AW-1:0]    rdAddr,
  input  wire logic [NUM_PORTS-1:0]                wrEn,
  input  wire logic [NUM_PORTS-1:0][RAM_AW-1:0]    wrAddr,
  input  wire logic [NUM_PORTS-1:0][31:0]          wrData,
  output logic      [NUM_PORTS-1:0][31:0]          rdData_q
);
  import region_protection_pkg::*;

  logic [31:0] mem [RAM_WORDS];

  // ****************************************************************
  // Storage.
  // ****************************************************************

  // Every port reads and writes in the same cycle with no arbitration stall;
  // on a shared write address the higher port index wins.
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (wrEn[p]) begin
        mem[wrAddr[p]] <= wrData[p];
      end
    end
  end

  // Read data is registered, one cycle after the enable.
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!reset_n) begin
        rdData_q[p] <= DATA_RESET;
      end else if (rdEn[p]) begin
        rdData_q[p] <= mem[rdAddr[p]];
      end
    end
  end

endmodule

// *** verilog/region_protection_pkg.sv ***
// Shared constants and types of the region protection unit.
package region_protection_pkg;

  // ****************************************************************
  // Sizes and primary indices.
  // ****************************************************************
  localparam int NUM_REGIONS = 8;
  localparam int NUM_PORTS   = 3;
  localparam int PORT_I      = 0;
  localparam int PORT_D      = 1;
  localparam int PORT_DMA    = 2;
  localparam int RAM_AW      = 10;
  localparam int RAM_WORDS   = 1024;

  // ****************************************************************
  // Memory types and lookup result.
  // ****************************************************************
  typedef enum logic [1:0] {
    MEM_NORMAL,
    MEM_DEVICE,
    MEM_STRONG
  } mem_type_e;

  typedef struct packed {
    logic      hit;
    logic      allowed;
    mem_type_e memType;
    logic      share;
    logic      xn;
  } lookup_s;

  // ****************************************************************
  // Background region attributes and reset values.
  // ****************************************************************
  localparam mem_type_e BG_TYPE     = MEM_NORMAL;
  localparam logic      BG_SHARE    = 1'b0;
  localparam logic      BG_XN       = 1'b0;
  localparam logic      READY_RESET = 1'b1;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;

endpackage

// *** verilog/region_protection_unit.sv ***
// Region protection unit guarding a multiport RAM for I, D and DMA primaries.
`timescale 1ns/1ps
// Behaviour
// - Eight regions plus an optional background region where nothing matches.
// - Each region has a type and attributes that decide access behaviour.
// - Normal-type accesses may be reordered ahead of buffered writes.
// - Device accesses keep order with other device and strongly-ordered accesses.
// - Strongly-ordered accesses keep order with all other accesses.
// - Device writes may be buffered; strongly-ordered writes never are.
// - Shareable regions stay coherent between processor and DMA.
// - Strongly-ordered regions are always treated as shareable.
// - Fetches from execute-never regions are blocked; fault only on execution.
// - A primary not permitted for a region raises a trap on access.
// - I, D and DMA reach the RAM together through separate ports, without arbitration wait cycles.
// - Regions can be restricted to privileged accesses.
module region_protection_unit
  import region_protection_pkg::*;
(
  input  wire logic                                     clk,
  input  wire logic                                     reset_n,
  input  wire logic      [NUM_REGIONS-1:0]              regionEnable,
  input  wire logic      [NUM_REGIONS-1:0][31:0]        regionBase,
  input  wire logic      [NUM_REGIONS-1:0][31:0]        regionLimit,
  input  wire mem_type_e [NUM_REGIONS-1:0]              regionType,
  input  wire logic      [NUM_REGIONS-1:0]              regionShare,
  input  wire logic      [NUM_REGIONS-1:0]              regionXn,
  input  wire logic      [NUM_REGIONS-1:0]              regionPrivOnly,
  input  wire logic      [NUM_REGIONS-1:0]              regionReadOnly,
  input  wire logic      [NUM_REGIONS-1:0][NUM_PORTS-1:0] regionPrimaryMask,
  input  wire logic                                     backgroundEnable,
  input  wire logic                                     iValid,
  input  wire logic      [31:0]                         iAddr,
  input  wire logic                                     iPriv,
  input  wire logic                                     iExecMarked,
  output logic                                          iRspValid,
  output logic           [31:0]                         iRspData,
  output logic                                          iRspXn,
  output logic                                          iFault,
  output logic                                          xnFault,
  input  wire logic                                     dValid,
  output logic                                          dReady,
  input  wire logic                                     dWrite,
  input  wire logic      [31:0]                         dAddr,
  input  wire logic      [31:0]                         dWdata,
  input  wire logic                                     dPriv,
  output logic                                          dRspValid,
  output logic           [31:0]                         dRspData,
  output logic                                          dFault,
  input  wire logic                                     dmaValid,
  output logic                                          dmaReady,
  input  wire logic                                     dmaWrite,
  input  wire logic      [31:0]                         dmaAddr,
  input  wire logic      [31:0]                         dmaWdata,
  output logic                                          dmaRspValid,
  output logic           [31:0]                         dmaRspData,
  output logic                                          dmaFault,
  output logic                                          trapPulse,
  output logic           [1:0]                          trapSource
);
  import region_protection_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    logic              bufValid;
    logic [RAM_AW-1:0] bufAddr;
    logic [31:0]       bufData;
    logic              dHold;
    logic              dHoldWrite;
    logic              dHoldPriv;
    logic [31:0]       dHoldAddr;
    logic [31:0]       dHoldData;
    logic              dmaHold;
    logic              dmaHoldWrite;
    logic [31:0]       dmaHoldAddr;
    logic [31:0]       dmaHoldData;
    logic              dReady;
    logic              dmaReady;
    logic              iRspValid;
    logic              iRspXn;
    logic              iFault;
    logic              xnFault;
    logic              dRspValid;
    logic              dFault;
    logic              dmaRspValid;
    logic              dmaFault;
    logic              trapPulse;
    logic [1:0]        trapSource;
  } state_s;

  localparam state_s STATE_RESET = '{dReady: READY_RESET, dmaReady: READY_RESET, default: '0};
  state_s s_q;
  state_s s_d;

  logic [NUM_PORTS-1:0]             ramRdEn;
  logic [NUM_PORTS-1:0]             ramWrEn;
  logic [NUM_PORTS-1:0][RAM_AW-1:0] ramRdAddr;
  logic [NUM_PORTS-1:0][RAM_AW-1:0] ramWrAddr;
  logic [NUM_PORTS-1:0][31:0]       ramWrData;
  logic [NUM_PORTS-1:0][31:0]       ramRdData;

  logic        dGo, dW, dP, dWait;
  logic [31:0] dA, dWd;
  logic        dmaGo, dmaW, dmaWait;
  logic [31:0] dmaA, dmaWd;
  lookup_s     iL, dL, dmaL;

  // ****************************************************************
  // Region lookup.
  // ****************************************************************
  // Background first, then regions in ascending order so the highest match wins.
  function automatic lookup_s lookup(input logic [31:0] addr, input logic priv,
                                     input logic write, input int port);
    lookup_s r;
    r.hit     = backgroundEnable;
    r.allowed = backgroundEnable & priv;
    r.memType = BG_TYPE;
    r.share   = BG_SHARE;
    r.xn      = BG_XN;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (regionEnable[i] && addr >= regionBase[i] && addr <= regionLimit[i]) begin
        r.hit     = 1'b1;
        r.memType = regionType[i];
        r.share   = regionShare[i];
        r.xn      = regionXn[i];
        r.allowed = regionPrimaryMask[i][port]
                    & (priv | ~regionPrivOnly[i])
                    & ~(write & regionReadOnly[i]);
      end
    end
    if (r.memType == MEM_STRONG) begin
      r.share = 1'b1;
    end
    if (!r.hit) begin
      r.allowed = 1'b0;
    end
    return r;
  endfunction

  // Request selection: a held request replays ahead of new ones.
  assign dGo   = s_q.dHold | (dValid & s_q.dReady);
  assign dW    = s_q.dHold ? s_q.dHoldWrite : dWrite;
  assign dP    = s_q.dHold ? s_q.dHoldPriv : dPriv;
  assign dA    = s_q.dHold ? s_q.dHoldAddr : dAddr;
  assign dWd   = s_q.dHold ? s_q.dHoldData : dWdata;
  assign dmaGo = s_q.dmaHold | (dmaValid & s_q.dmaReady);
  assign dmaW  = s_q.dmaHold ? s_q.dmaHoldWrite : dmaWrite;
  assign dmaA  = s_q.dmaHold ? s_q.dmaHoldAddr : dmaAddr;
  assign dmaWd = s_q.dmaHold ? s_q.dmaHoldData : dmaWdata;

  // Lookups run in processes so that a change of region settings alone wakes them.
  always_comb iL   = lookup(iAddr, iPriv, 1'b0, PORT_I);
  always_comb dL   = lookup(dA, dP, dW, PORT_D);
  always_comb dmaL = lookup(dmaA, 1'b1, dmaW, PORT_DMA);

  // D waits behind a buffered write for strong accesses, device reads, same-word reads.
  assign dWait = s_q.bufValid & ((dL.memType == MEM_STRONG)
               | (dL.memType == MEM_DEVICE & ~dW)
               | (~dW & dA[RAM_AW+1:2] == s_q.bufAddr));

  // DMA waits for a pending processor write before touching shared data.
  assign dmaWait = s_q.bufValid & dmaL.share;

  // ****************************************************************
  // Next state and RAM control.
  // ****************************************************************
  // Fills the next state and steers the three RAM ports.
  always_comb begin
    s_d             = s_q;
    s_d.iRspValid   = 1'b0;
    s_d.iRspXn      = 1'b0;
    s_d.iFault      = 1'b0;
    s_d.dRspValid   = 1'b0;
    s_d.dFault      = 1'b0;
    s_d.dmaRspValid = 1'b0;
    s_d.dmaFault    = 1'b0;
    s_d.trapPulse   = 1'b0;
    s_d.bufValid    = 1'b0;
    s_d.dHold       = 1'b0;
    s_d.dmaHold     = 1'b0;
    s_d.dReady      = 1'b1;
    s_d.dmaReady    = 1'b1;
    s_d.xnFault     = iExecMarked;
    ramRdEn         = '0;
    ramWrEn         = '0;
    ramRdAddr[PORT_I]   = iAddr[RAM_AW+1:2];
    ramRdAddr[PORT_D]   = dA[RAM_AW+1:2];
    ramRdAddr[PORT_DMA] = dmaA[RAM_AW+1:2];
    ramWrAddr[PORT_I]   = '0;
    ramWrData[PORT_I]   = '0;
    ramWrAddr[PORT_D]   = s_q.bufValid ? s_q.bufAddr : dA[RAM_AW+1:2];
    ramWrData[PORT_D]   = s_q.bufValid ? s_q.bufData : dWd;
    ramWrAddr[PORT_DMA] = dmaA[RAM_AW+1:2];
    ramWrData[PORT_DMA] = dmaWd;
    // The write buffer drains every cycle, so a D wait lasts one cycle.
    ramWrEn[PORT_D]     = s_q.bufValid;

    // Instruction fetch port: always taken, never stalled.
    if (iValid) begin
      s_d.iRspValid = 1'b1;
      if (!iL.allowed) begin
        s_d.iFault = 1'b1;
      end else if (iL.xn) begin
        s_d.iRspXn = 1'b1;
      end else begin
        ramRdEn[PORT_I] = 1'b1;
      end
    end

    // Data port.
    if (dGo) begin
      if (!dL.allowed) begin
        s_d.dRspValid = 1'b1;
        s_d.dFault    = 1'b1;
      end else if (dWait) begin
        s_d.dHold      = 1'b1;
        s_d.dHoldWrite = dW;
        s_d.dHoldPriv  = dP;
        s_d.dHoldAddr  = dA;
        s_d.dHoldData  = dWd;
        s_d.dReady     = 1'b0;
      end else begin
        s_d.dRspValid = 1'b1;
        if (dW && dL.memType == MEM_STRONG) begin
          ramWrEn[PORT_D] = 1'b1;
        end else if (dW) begin
          s_d.bufValid = 1'b1;
          s_d.bufAddr  = dA[RAM_AW+1:2];
          s_d.bufData  = dWd;
        end else begin
          ramRdEn[PORT_D] = 1'b1;
        end
      end
    end

    // DMA port.
    if (dmaGo) begin
      if (!dmaL.allowed) begin
        s_d.dmaRspValid = 1'b1;
        s_d.dmaFault    = 1'b1;
      end else if (dmaWait) begin
        s_d.dmaHold      = 1'b1;
        s_d.dmaHoldWrite = dmaW;
        s_d.dmaHoldAddr  = dmaA;
        s_d.dmaHoldData  = dmaWd;
        s_d.dmaReady     = 1'b0;
      end else begin
        s_d.dmaRspValid    = 1'b1;
        ramWrEn[PORT_DMA]  = dmaW;
        ramRdEn[PORT_DMA]  = ~dmaW;
      end
    end

    // One trap pulse, data port reported first, then DMA, then fetch.
    s_d.trapPulse = s_d.dFault | s_d.dmaFault | s_d.iFault;
    if (s_d.dFault) begin
      s_d.trapSource = 2'(PORT_D);
    end else if (s_d.dmaFault) begin
      s_d.trapSource = 2'(PORT_DMA);
    end else if (s_d.iFault) begin
      s_d.trapSource = 2'(PORT_I);
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // RAM and outputs.
  // ****************************************************************
  // Each primary has its own RAM port, so no access waits for a port; shared DMA accesses still wait behind a buffered D write.
  multiport_ram u_ram (
    .clk      (clk),
    .reset_n  (reset_n),
    .rdEn     (ramRdEn),
    .rdAddr   (ramRdAddr),
    .wrEn     (ramWrEn),
    .wrAddr   (ramWrAddr),
    .wrData   (ramWrData),
    .rdData_q (ramRdData)
  );

  // Outputs come from the state register or the RAM read register.
  assign iRspValid   = s_q.iRspValid;
  assign iRspData    = ramRdData[PORT_I];
  assign iRspXn      = s_q.iRspXn;
  assign iFault      = s_q.iFault;
  assign xnFault     = s_q.xnFault;
  assign dReady      = s_q.dReady;
  assign dRspValid   = s_q.dRspValid;
  assign dRspData    = ramRdData[PORT_D];
  assign dFault      = s_q.dFault;
  assign dmaReady    = s_q.dmaReady;
  assign dmaRspValid = s_q.dmaRspValid;
  assign dmaRspData  = ramRdData[PORT_DMA];
  assign dmaFault    = s_q.dmaFault;
  assign trapPulse   = s_q.trapPulse;
  assign trapSource  = s_q.trapSource;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  so_nobuf_a: assert property (dGo && dW && !dWait && dL.memType == MEM_STRONG
      && dL.allowed |-> ramWrEn[PORT_D] ##1 !s_q.bufValid) else $error("strong write buffered");
  dev_buf_a: assert property (dGo && dW && dL.allowed && dL.memType == MEM_DEVICE
      |=> s_q.bufValid && dRspValid) else $error("device write not buffered");
  so_order_a: assert property (s_q.bufValid && dGo && dL.allowed
      && dL.memType == MEM_STRONG |=> !dRspValid ##1 dRspValid) else $error("order broken");
  dev_order_a: assert property (dGo && !dW && dL.allowed && dL.memType == MEM_DEVICE
      && !s_q.bufValid |=> dRspValid) else $error("device read stalled without cause");
  dma_share_a: assert property (dmaGo && dmaL.allowed && dmaL.share
      |-> !s_q.bufValid or ##1 (!dmaReady ##1 dmaRspValid)) else $error("shared DMA raced");
  so_share_a: assert property (dmaGo && dmaL.allowed && s_q.bufValid
      && dmaL.memType == MEM_STRONG |=> !dmaRspValid) else $error("strong region not shared");
  xn_block_a: assert property (iValid && iL.allowed && iL.xn
      |=> iRspValid && iRspXn && !$past(ramRdEn[PORT_I])) else $error("fetch from xn region");
  xn_fault_a: assert property (xnFault == $past(iExecMarked))
      else $error("xn fault not tied to execution");
  trap_a: assert property ((dGo && !dL.allowed) || (dmaGo && !dmaL.allowed)
      || (iValid && !iL.allowed) |=> trapPulse) else $error("missing trap");
  no_wait_a: assert property (iValid && iL.allowed && !iL.xn
      |=> iRspValid && !iFault) else $error("fetch delayed");
  no_match_a: assert property (dGo && !dL.hit |=> dFault && dRspValid)
      else $error("unmatched access not faulted");

endmodule
